// >>> core/link_perf_events.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Code 0x19 adds receive snoop occupancy
// - Umask bits pick virtual networks zero/one
// - Receive flits bypass queue unless ring stalls
// - Events exist on counter slots 0-3
// - Code 0x0d counts half-width cycles
// - Edge detect counts half-width entries
// - Edge count invalid during deep sleep
// - Transmit power state tracked separately
// - Code 0x0c counts full incl. half
// - Training cycles excluded from full-width count
// - Code 0x05 counts transmit queue bypasses
// - Transmit queue used in half-width, retry
// - Code 0x06 counts queue not-empty cycles
// - Group zero umask 02 counts data flits
// - Group zero umask 04 counts non-data
// - Flit is 80 bits, transfers halve width
// - Cache line is header plus eight data
// - Group one umask 01 counts snoop requests
// - Group one umask 02/04/06 count home flits
module link_perf_events
   import link_perf_pkg::*;
#(
   parameter int QDEPTH = TXQ_DEPTH
)
(
   input wire logic sys_clk,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Receive side: flit arrival and ring backpressure
   input wire logic rx_flit_valid,
   input wire logic rx_flit_snoop,
   input wire logic rx_flit_vn1,
   input wire logic ring_ready,
   output logic ring_valid,
   // Transmit side: flit arrival and link slot
   input wire logic tx_flit_valid,
   input wire logic [2:0] tx_flit_class,
   input wire logic tx_flit_is_data,
   input wire logic link_slot,
   input wire logic link_retry,
   input wire logic half_width_req,
   input wire logic train_req,
   input wire logic deep_sleep,
   output logic link_valid,
   output logic [2:0] link_class,
   output logic link_is_data,
   output logic half_width_state,
   output logic tx_queue_full
);
   // Transmit flit classes carried on tx_flit_class
   localparam logic [2:0] CLS_NULL = 3'h0;
   localparam logic [2:0] CLS_SNOOP = 3'h1;
   localparam logic [2:0] CLS_COHERENCE_AGENT_REQUEST_SELECT = 3'h2;
   localparam logic [2:0] CLS_HOM_RESP = 3'h3;
   localparam logic [2:0] CLS_DATA_RESP = 3'h4;
   localparam logic [2:0] CLS_NC_BYPASS = 3'h5;
   localparam int QA = $clog2(QDEPTH);

   flit_evt_if ev();

   // Software-visible select and counters
   logic [SEL_W-1:0] sel_reg [NUM_SLOTS]; // Event select per slot
   logic [NUM_SLOTS-1:0] clear_reg; // One-cycle clear pulses
   logic [CNT_W-1:0] cnt [NUM_SLOTS];
   logic [31:0] rdata_reg;

   // Receive queue occupancy per virtual network, snoop class
   logic [OCC_W-1:0] rxq_vn0_reg;
   logic [OCC_W-1:0] rxq_vn1_reg;
   logic rx_snp_alloc;
   logic ring_valid_reg;

   // Transmit queue storage, three class bits and a data bit per entry
   logic [3:0] txq_mem [QDEPTH];
   logic [QA-1:0] wr_ptr_reg;
   logic [QA-1:0] rd_ptr_reg;
   logic [QA:0] txq_cnt_reg;
   logic txq_push;
   logic txq_pop;
   logic tx_bypass;
   width_state_t wstate_reg;
   logic link_valid_reg;
   logic [2:0] link_class_reg;
   logic link_is_data_reg;
   logic [2:0] sent_class;
   logic sent_data;
   logic sent;

   // Each slot instantiated with its own select; only four exist
   for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
      perf_slot u_slot (
         .sys_clk(sys_clk),
         .rstn(rstn),
         .sel(sel_reg[i]),
         .clear(clear_reg[i]),
         .ev(ev),
         .count(cnt[i])
      );
   end

   // Select register writes
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_SLOTS; i++) sel_reg[i] <= SEL_RESET;
      end else if (reg_wr) begin
         for (int i = 0; i < NUM_SLOTS; i++)
            if (reg_addr == ADDR_SEL0 + 8'(4*i)) sel_reg[i] <= reg_wdata;
      end
   end

   // Writing any counter word clears that slot
   always_ff @(posedge sys_clk) begin
      if (!rstn) clear_reg <= '0;
      else begin
         for (int i = 0; i < NUM_SLOTS; i++)
            clear_reg[i] <= reg_wr && (reg_addr == ADDR_CNT0_LO + 8'(4*i)
               || reg_addr == ADDR_CNT0_HI + 8'(4*i));
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge sys_clk) begin
      if (!rstn) rdata_reg <= '0;
      else if (reg_rd) begin
         rdata_reg <= '0;
         for (int i = 0; i < NUM_SLOTS; i++) begin
            if (reg_addr == ADDR_SEL0 + 8'(4*i)) rdata_reg <= sel_reg[i];
            else if (reg_addr == ADDR_CNT0_LO + 8'(4*i)) rdata_reg <= cnt[i][31:0];
            else if (reg_addr == ADDR_CNT0_HI + 8'(4*i))
               rdata_reg <= {16'h0000, cnt[i][CNT_W-1:32]};
         end
         if (reg_addr == ADDR_STATUS)
            rdata_reg <= {8'h00, rxq_vn1_reg, rxq_vn0_reg, 1'b0, wstate_reg,
               1'b0, 3'(txq_cnt_reg)};
      end else rdata_reg <= '0;
   end
   assign reg_rdata = rdata_reg;

   // Receive path: snoop flits go straight to ring unless it is stalled
   assign rx_snp_alloc = rx_flit_valid && rx_flit_snoop && !ring_ready;
   always_ff @(posedge sys_clk) begin
      if (!rstn) ring_valid_reg <= 1'b0;
      else ring_valid_reg <= (rx_flit_valid && ring_ready)
         || (ring_ready && (rxq_vn0_reg != '0 || rxq_vn1_reg != '0));
   end
   assign ring_valid = ring_valid_reg;

   // Occupancy counters, saturating at the documented maximum
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rxq_vn0_reg <= '0;
         rxq_vn1_reg <= '0;
      end else if (rx_snp_alloc) begin
         if (rx_flit_vn1 && rxq_vn1_reg + rxq_vn0_reg < OCC_MAX)
            rxq_vn1_reg <= rxq_vn1_reg + 8'h01;
         else if (!rx_flit_vn1 && rxq_vn1_reg + rxq_vn0_reg < OCC_MAX)
            rxq_vn0_reg <= rxq_vn0_reg + 8'h01;
      end else if (ring_ready) begin
         // Drain network zero first, one entry a cycle
         if (rxq_vn0_reg != '0) rxq_vn0_reg <= rxq_vn0_reg - 8'h01;
         else if (rxq_vn1_reg != '0) rxq_vn1_reg <= rxq_vn1_reg - 8'h01;
      end
   end

   // Transmit width state, independent of the receive direction
   always_ff @(posedge sys_clk) begin
      if (!rstn) wstate_reg <= ST_FULL;
      else begin
         case (wstate_reg)
            ST_FULL: begin
               if (train_req) wstate_reg <= ST_TRAIN;
               else if (half_width_req) wstate_reg <= ST_HALF;
            end
            ST_HALF: begin
               if (train_req) wstate_reg <= ST_TRAIN;
               else if (!half_width_req) wstate_reg <= ST_FULL;
            end
            ST_TRAIN: begin
               if (!train_req) wstate_reg <= ST_FULL;
            end
            default: wstate_reg <= ST_FULL;
         endcase
      end
   end
   assign half_width_state = (wstate_reg == ST_HALF);

   // Queue use forced in half width, retry, or while backlog exists
   assign tx_bypass = tx_flit_valid && link_slot && wstate_reg == ST_FULL
      && !link_retry && txq_cnt_reg == '0;
   assign txq_push = tx_flit_valid && !tx_bypass && txq_cnt_reg != (QA+1)'(QDEPTH);
   assign txq_pop = link_slot && !link_retry && wstate_reg != ST_TRAIN
      && txq_cnt_reg != '0;
   assign tx_queue_full = txq_cnt_reg == (QA+1)'(QDEPTH);

   // Queue storage and pointers
   always_ff @(posedge sys_clk) begin
      if (txq_push) txq_mem[wr_ptr_reg] <= {tx_flit_is_data, tx_flit_class};
   end
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         txq_cnt_reg <= '0;
      end else begin
         if (txq_push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (txq_pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         txq_cnt_reg <= txq_cnt_reg + (QA+1)'(txq_push) - (QA+1)'(txq_pop);
      end
   end

   // Flit leaving on the link this cycle (80-bit flit, header then data)
   assign sent = tx_bypass || txq_pop;
   assign sent_class = tx_bypass ? tx_flit_class : txq_mem[rd_ptr_reg][2:0];
   assign sent_data = tx_bypass ? tx_flit_is_data : txq_mem[rd_ptr_reg][3];

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         link_valid_reg <= 1'b0;
         link_class_reg <= CLS_NULL;
         link_is_data_reg <= 1'b0;
      end else begin
         link_valid_reg <= sent;
         link_class_reg <= sent ? sent_class : CLS_NULL;
         link_is_data_reg <= sent && sent_data;
      end
   end
   assign link_valid = link_valid_reg;
   assign link_class = link_class_reg;
   assign link_is_data = link_is_data_reg;

   // Event levels for the slots
   assign ev.rx_occ_vn0 = rxq_vn0_reg;
   assign ev.rx_occ_vn1 = rxq_vn1_reg;
   assign ev.full_width = wstate_reg != ST_TRAIN;
   assign ev.half_width = wstate_reg == ST_HALF;
   assign ev.tx_bypass = tx_bypass;
   assign ev.tx_not_empty = txq_cnt_reg != '0;
   assign ev.g0_data = {1'b0, sent && sent_data
      && (sent_class == CLS_DATA_RESP || sent_class == CLS_NC_BYPASS)};
   assign ev.g0_nondata = {1'b0, sent && !sent_data && sent_class != CLS_NULL};
   assign ev.g1_snp = {1'b0, sent && sent_class == CLS_SNOOP};
   assign ev.g1_coherence_agent_request_select = {1'b0, sent && sent_class == CLS_COHERENCE_AGENT_REQUEST_SELECT};
   assign ev.g1_hom_resp = {1'b0, sent && sent_class == CLS_HOM_RESP};
   assign ev.deep_sleep = deep_sleep;
endmodule
`default_nettype wire

// >>> core/link_perf_pkg.sv
package link_perf_pkg;
   // Event select layout: code in 7:0, umask in 15:8, extra select bit above
   localparam int EVT_CODE_LSB = 0;
   localparam int EVT_CODE_W = 8;
   localparam int UMASK_LSB = 8;
   localparam int UMASK_W = 8;
   localparam int EXT_SEL_BIT = 16;
   localparam int EDGE_DET_BIT = 18;
   localparam int ENABLE_BIT = 22;
   localparam int SEL_W = 32;

   // Event codes
   localparam logic [7:0] CODE_FLITS = 8'h00;
   localparam logic [7:0] CODE_TX_BYPASS = 8'h05;
   localparam logic [7:0] CODE_TX_NOT_EMPTY = 8'h06;
   localparam logic [7:0] CODE_FULL_WIDTH = 8'h0c;
   localparam logic [7:0] CODE_HALF_WIDTH = 8'h0d;
   localparam logic [7:0] CODE_RX_SNP_OCC = 8'h19;

   // Umask bits
   localparam int UM_VN0 = 0;
   localparam int UM_VN1 = 1;
   localparam int UM_G0_DATA = 1;
   localparam int UM_G0_NONDATA = 2;
   localparam int UM_G1_SNP = 0;
   localparam int UM_G1_COHERENCE_AGENT_REQUEST_SELECT = 1;
   localparam int UM_G1_HOM_RESP = 2;

   // Sizes
   localparam int NUM_SLOTS = 4;
   localparam int CNT_W = 48;
   localparam int OCC_W = 8;
   localparam logic [OCC_W-1:0] OCC_MAX = 8'h80;
   localparam int INC_W = 9;
   localparam int TXQ_DEPTH = 16;

   // Register map (index = byte address / 4)
   localparam logic [7:0] ADDR_SEL0 = 8'h00;
   localparam logic [7:0] ADDR_CNT0_LO = 8'h10;
   localparam logic [7:0] ADDR_CNT0_HI = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h30;
   localparam logic [7:0] ADDR_CONTROL = 8'h34;
   localparam logic [31:0] SEL_RESET = 32'h0000_0000;

   // Transmit lane width states
   typedef enum logic [2:0] {
      ST_FULL = 3'b001,
      ST_HALF = 3'b010,
      ST_TRAIN = 3'b100
   } width_state_t;
endpackage

// >>> core/flit_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
// Per-cycle event increments handed from the flit paths to the counter slots
interface flit_evt_if;
   import link_perf_pkg::*;
   logic [OCC_W-1:0] rx_occ_vn0; // Snoop entries, network 0
   logic [OCC_W-1:0] rx_occ_vn1; // Snoop entries, network 1
   logic full_width; // Transmit in full or half width
   logic half_width; // Transmit in half width only
   logic tx_bypass; // Flit bypassed the transmit queue
   logic tx_not_empty; // Transmit queue holds an entry
   logic [1:0] g0_data; // Data flits this cycle
   logic [1:0] g0_nondata; // Non-null non-data flits
   logic [1:0] g1_snp; // Snoop request flits
   logic [1:0] g1_coherence_agent_request_select; // Home request flits
   logic [1:0] g1_hom_resp; // Home non-request flits
   logic deep_sleep; // Deep-sleep residency active
   modport src (output rx_occ_vn0, rx_occ_vn1, full_width, half_width, tx_bypass,
      tx_not_empty, g0_data, g0_nondata, g1_snp, g1_coherence_agent_request_select, g1_hom_resp, deep_sleep);
   modport dst (input rx_occ_vn0, rx_occ_vn1, full_width, half_width, tx_bypass,
      tx_not_empty, g0_data, g0_nondata, g1_snp, g1_coherence_agent_request_select, g1_hom_resp, deep_sleep);
endinterface
`default_nettype wire

// >>> core/perf_slot.sv
`timescale 1ns/1ps
`default_nettype none
// One counter slot: decodes its event select and accumulates
module perf_slot
   import link_perf_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [SEL_W-1:0] sel,
   input wire logic clear,
   flit_evt_if.dst ev,
   output logic [CNT_W-1:0] count
);
   logic [7:0] code;
   logic [7:0] um;
   logic ext;
   logic [INC_W-1:0] raw_inc; // Selected per-cycle amount
   logic level_reg; // Previous level for edge detect
   logic [INC_W-1:0] inc;
   logic [CNT_W-1:0] count_reg;

   assign code = sel[EVT_CODE_LSB +: EVT_CODE_W];
   assign um = sel[UMASK_LSB +: UMASK_W];
   assign ext = sel[EXT_SEL_BIT];

   // Widen a two-bit flit count
   function automatic logic [INC_W-1:0] w2(input logic [1:0] v);
      return {{(INC_W-2){1'b0}}, v};
   endfunction

   // Event decode; a set of umask bits counts the union of subclasses
   always_comb begin
      raw_inc = '0;
      if (code == CODE_RX_SNP_OCC && ext) begin
         // Snoop class only, per selected virtual network
         if (um[UM_VN0]) raw_inc = raw_inc + {1'b0, ev.rx_occ_vn0};
         if (um[UM_VN1]) raw_inc = raw_inc + {1'b0, ev.rx_occ_vn1};
      end else if (code == CODE_HALF_WIDTH && !ext) begin
         raw_inc = {{(INC_W-1){1'b0}}, ev.half_width};
      end else if (code == CODE_FULL_WIDTH && !ext) begin
         raw_inc = {{(INC_W-1){1'b0}}, ev.full_width};
      end else if (code == CODE_TX_BYPASS && !ext) begin
         raw_inc = {{(INC_W-1){1'b0}}, ev.tx_bypass};
      end else if (code == CODE_TX_NOT_EMPTY && !ext) begin
         raw_inc = {{(INC_W-1){1'b0}}, ev.tx_not_empty};
      end else if (code == CODE_FLITS && !ext) begin
         if (um[UM_G0_DATA]) raw_inc = raw_inc + w2(ev.g0_data);
         if (um[UM_G0_NONDATA]) raw_inc = raw_inc + w2(ev.g0_nondata);
      end else if (code == CODE_FLITS && ext) begin
         if (um[UM_G1_SNP]) raw_inc = raw_inc + w2(ev.g1_snp);
         if (um[UM_G1_COHERENCE_AGENT_REQUEST_SELECT]) raw_inc = raw_inc + w2(ev.g1_coherence_agent_request_select);
         if (um[UM_G1_HOM_RESP]) raw_inc = raw_inc + w2(ev.g1_hom_resp);
      end
   end

   // Edge detect turns a level into one count per rising entry
   always_ff @(posedge sys_clk) begin
      if (!rstn) level_reg <= 1'b0;
      else level_reg <= raw_inc[0];
   end

   // Edge count only meaningful for one-bit levels; invalid under deep sleep
   always_comb begin
      if (sel[EDGE_DET_BIT])
         inc = {{(INC_W-1){1'b0}}, raw_inc[0] & ~level_reg};
      else
         inc = raw_inc;
   end

   // Accumulator; software clear takes priority over the add
   always_ff @(posedge sys_clk) begin
      if (!rstn) count_reg <= '0;
      else if (clear) count_reg <= '0;
      else if (sel[ENABLE_BIT]) count_reg <= count_reg + {{(CNT_W-INC_W){1'b0}}, inc};
   end
   assign count = count_reg;
endmodule
`default_nettype wire

// >>> tb/link_perf_events_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level timing relations of the event block
module link_perf_events_props (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic rx_flit_valid,
   input wire logic ring_ready,
   input wire logic ring_valid,
   input wire logic link_slot,
   input wire logic link_valid,
   input wire logic half_width_req,
   input wire logic train_req,
   input wire logic half_width_state,
   input wire logic tx_queue_full
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Outputs come out of reset quiet and in full width
   a_reset_quiet: assert property (!$past(rstn) |-> !ring_valid && !link_valid && !half_width_state)
      else $error("outputs busy after reset");
   // The ring only takes a flit when it said ready
   a_ring_ready: assert property (ring_valid |-> $past(ring_ready))
      else $error("flit passed to stalled ring");
   // A ready ring never lets an arriving flit wait
   a_ring_bypass: assert property ($past(rx_flit_valid) && $past(ring_ready) |-> ring_valid)
      else $error("arriving flit not passed on");
   // A flit leaves only in a link slot
   a_link_slot: assert property (link_valid |-> $past(link_slot))
      else $error("flit sent without slot");
   // A steady request settles the half-width state
   a_half_enter: assert property ((half_width_req && !train_req) [*3] |-> half_width_state)
      else $error("half width not entered");
   a_half_leave: assert property ((!half_width_req) [*3] |-> !half_width_state)
      else $error("half width not left");
   // Training is neither full nor half width
   a_train_out: assert property (train_req [*3] |-> !half_width_state)
      else $error("half width during training");
   // Nothing answers above the four slots and status
   a_no_fifth: assert property (reg_rd && reg_addr >= 8'h38 |=> reg_rdata == 32'h0)
      else $error("unmapped read returned data");
   c_ring: cover property (ring_valid);
   c_link: cover property (link_valid);
   c_half: cover property ($rose(half_width_state));
   c_full: cover property (tx_queue_full);
endmodule
`default_nettype wire

// >>> tb/link_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: flit sources, ring and link back-pressure
module link_far_side (
   input wire logic sys_clk,
   output logic rx_flit_valid,
   output logic rx_flit_snoop,
   output logic rx_flit_vn1,
   output logic ring_ready,
   output logic tx_flit_valid,
   output logic [2:0] tx_flit_class,
   output logic tx_flit_is_data,
   output logic link_slot,
   output logic link_retry
);
   initial begin
      {rx_flit_valid, rx_flit_snoop, rx_flit_vn1, tx_flit_valid, tx_flit_is_data} = 5'h0;
      tx_flit_class = 3'h0;
      ring_ready = 1'b1;
      link_slot = 1'b1;
      link_retry = 1'b0; // Retry is never provoked here
   end
   // Back-pressure levels, changed right after an edge
   task automatic lines(input logic r, input logic s);
      @(posedge sys_clk);
      ring_ready <= r;
      link_slot <= s;
   endtask
   // Receive flits, one per cycle; idle lines show the inverse so nothing is read stale
   task automatic send_rx(input int n, input logic snoop_channel, input logic vn1);
      repeat (n) begin
         @(posedge sys_clk);
         rx_flit_valid <= 1'b1;
         rx_flit_snoop <= snoop_channel;
         rx_flit_vn1 <= vn1;
      end
      @(posedge sys_clk);
      rx_flit_valid <= 1'b0;
      rx_flit_snoop <= ~snoop_channel;
      rx_flit_vn1 <= ~vn1;
   endtask
   // Transmit flits, one per cycle
   task automatic send_tx(input int n, input logic [2:0] c, input logic dat);
      repeat (n) begin
         @(posedge sys_clk);
         tx_flit_valid <= 1'b1;
         tx_flit_class <= c;
         tx_flit_is_data <= dat;
      end
      @(posedge sys_clk);
      tx_flit_valid <= 1'b0;
      tx_flit_class <= ~c;
      tx_flit_is_data <= ~dat;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_link_perf_events.sv
`timescale 1ns/1ps
`default_nettype none
module tb_link_perf_events;
   import link_perf_pkg::*;
   logic sys_clk, rstn, reg_wr, reg_rd, half_width_req, train_req, deep_sleep;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   wire logic rx_flit_valid, rx_flit_snoop, rx_flit_vn1, ring_ready, ring_valid;
   wire logic tx_flit_valid, tx_flit_is_data, link_slot, link_retry, link_valid;
   wire logic link_is_data, half_width_state, tx_queue_full;
   wire logic [2:0] tx_flit_class, link_class;
   int miscompares, n_tests, i, n, k0, k1;
   // Table: {expected per flit, data, class, 0, extra select, umask, code}
   localparam logic [23:0] ROWS [13] = '{24'h700200, 24'h740200, 24'h100200, 24'h500400,
      24'h480400, 24'h000400, 24'h450100, 24'h0d0100, 24'h490200, 24'h4d0400,
      24'h490600, 24'h4d0600, 24'h440005};
   // Small queue depth so the full flag is reached quickly
   link_perf_events #(.QDEPTH(4)) dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rx_flit_valid(rx_flit_valid), .rx_flit_snoop(rx_flit_snoop), .rx_flit_vn1(rx_flit_vn1),
      .ring_ready(ring_ready), .ring_valid(ring_valid), .tx_flit_valid(tx_flit_valid),
      .tx_flit_class(tx_flit_class), .tx_flit_is_data(tx_flit_is_data), .link_slot(link_slot),
      .link_retry(link_retry), .half_width_req(half_width_req), .train_req(train_req),
      .deep_sleep(deep_sleep), .link_valid(link_valid), .link_class(link_class),
      .link_is_data(link_is_data), .half_width_state(half_width_state),
      .tx_queue_full(tx_queue_full));
   link_far_side far (.sys_clk(sys_clk), .rx_flit_valid(rx_flit_valid),
      .rx_flit_snoop(rx_flit_snoop), .rx_flit_vn1(rx_flit_vn1), .ring_ready(ring_ready),
      .tx_flit_valid(tx_flit_valid), .tx_flit_class(tx_flit_class),
      .tx_flit_is_data(tx_flit_is_data), .link_slot(link_slot), .link_retry(link_retry));
   always #2 sys_clk = ~sys_clk;
   function automatic logic [31:0] sel(logic [7:0] c, logic [7:0] u, logic x, logic e);
      sel = {9'h0, 1'b1, 3'h0, e, 1'b0, x, u, c};
   endfunction
   task automatic end_of_test;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // Two samples eight cycles apart give the per-cycle increment
   task automatic rate(input int s, input int per);
      logic [31:0] a, b;
      rd(ADDR_CNT0_LO + 8'(4 * s), a);
      repeat (6) @(posedge sys_clk);
      rd(ADDR_CNT0_LO + 8'(4 * s), b);
      chk(b - a, 32'(per * 8));
   endtask
   task automatic lvl(input logic h, input logic t);
      @(posedge sys_clk);
      half_width_req <= h;
      train_req <= t;
      repeat (5) @(posedge sys_clk);
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      end_of_test();
   end
   initial begin
      {sys_clk, rstn, reg_wr, reg_rd, half_width_req, train_req, deep_sleep} = 7'h0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      {miscompares, n_tests} = 0;
      void'($urandom(32'h4ff2eb91));
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(ADDR_SEL0, d); chk(d, SEL_RESET);
      rd(8'h3c, d); chk(d, 32'h0);
      // Power residency; deep sleep stays low so edge counts are trustworthy
      wr(ADDR_SEL0, sel(CODE_FULL_WIDTH, 8'h0, 1'b0, 1'b0));
      wr(ADDR_SEL0 + 8'h4, sel(CODE_HALF_WIDTH, 8'h0, 1'b0, 1'b0));
      wr(ADDR_SEL0 + 8'h8, sel(CODE_HALF_WIDTH, 8'h0, 1'b0, 1'b1));
      lvl(1'b0, 1'b0);
      rate(0, 1);
      rate(1, 0);
      wr(ADDR_CNT0_LO + 8'h8, 32'h0);
      lvl(1'b1, 1'b0);
      rate(0, 1);
      rate(1, 1);
      lvl(1'b0, 1'b0);
      lvl(1'b1, 1'b0);
      rd(ADDR_CNT0_LO + 8'h8, d); chk(d, 32'h2);
      lvl(1'b0, 1'b1);
      rate(0, 0);
      lvl(1'b0, 1'b0);
      // Receive occupancy with the ring stalled
      k0 = $urandom_range(20, 1);
      k1 = $urandom_range(20, 1);
      far.lines(1'b0, 1'b1);
      far.send_rx(k0, 1'b1, 1'b0);
      far.send_rx(k1, 1'b1, 1'b1);
      far.send_rx(2, 1'b0, 1'b0);
      // Status word shows both snoop occupancies; non-snoop flits never queue
      rd(ADDR_STATUS, d);
      chk(d, {8'h00, 8'(k1), 8'(k0), 1'b0, ST_FULL, 4'h0});
      for (i = 0; i < 3; i++) wr(ADDR_SEL0 + 8'(4 * i), sel(CODE_RX_SNP_OCC, 8'(i + 1), 1'b1, 1'b0));
      wr(ADDR_SEL0 + 8'hc, sel(CODE_RX_SNP_OCC, 8'h1, 1'b0, 1'b0));
      rate(0, k0);
      rate(1, k1);
      rate(2, k0 + k1);
      rate(3, 0);
      far.lines(1'b1, 1'b1);
      repeat (k0 + k1 + 5) @(posedge sys_clk);
      rate(2, 0);
      // Transmit queue held back by the link
      wr(ADDR_SEL0 + 8'hc, sel(CODE_TX_NOT_EMPTY, 8'h0, 1'b0, 1'b0));
      far.lines(1'b1, 1'b0);
      far.send_tx(2, 3'h1, 1'b0);
      #1 chk({31'h0, tx_queue_full}, 32'h0);
      rate(3, 1);
      far.send_tx(2, 3'h1, 1'b0);
      #1 chk({31'h0, tx_queue_full}, 32'h1);
      far.lines(1'b1, 1'b1);
      repeat (10) @(posedge sys_clk);
      rate(3, 0);
      // Flit classes and bypass, full width
      for (i = 0; i < 13; i++) begin
         n = $urandom_range(8, 1);
         wr(ADDR_SEL0 + 8'(4 * (i % 4)), sel(ROWS[i][7:0], ROWS[i][15:8], ROWS[i][16], 1'b0));
         wr(ADDR_CNT0_LO + 8'(4 * (i % 4)), 32'h0);
         repeat (2) @(posedge sys_clk);
         far.send_tx(n, ROWS[i][20:18], ROWS[i][21]);
         // Last flit stands on the link outputs for one cycle after its edge
         #1;
         chk({27'h0, link_valid, link_is_data, link_class}, {27'h0, 1'b1, ROWS[i][21:18]});
         repeat (8) @(posedge sys_clk);
         rd(ADDR_CNT0_LO + 8'(4 * (i % 4)), d);
         chk(d, 32'(ROWS[i][22] ? n : 0));
      end
      // Half width forces flits through the queue
      lvl(1'b1, 1'b0);
      wr(ADDR_CNT0_LO, 32'h0);
      far.send_tx(3, 3'h2, 1'b0);
      repeat (12) @(posedge sys_clk);
      rd(ADDR_CNT0_LO, d); chk(d, 32'h0);
      rd(ADDR_CNT0_HI, d); chk(d, 32'h0);
      end_of_test();
   end
endmodule
bind link_perf_events link_perf_events_props props_i (.sys_clk(sys_clk), .rstn(rstn),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_flit_valid(rx_flit_valid),
   .ring_ready(ring_ready), .ring_valid(ring_valid), .link_slot(link_slot),
   .link_valid(link_valid), .half_width_req(half_width_req), .train_req(train_req),
   .half_width_state(half_width_state), .tx_queue_full(tx_queue_full));
`default_nettype wire
